// ### rtl/hdr_table_rom.sv
`timescale 1ns/100ps
module hdr_table_rom #(
   parameter logic [7:0] MAKER_ID = hdr_table_pkg::V_MAKER_DEFAULT
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // Serial pins from the host
   input wire logic SCK,
   input wire logic CS_N,
   input wire logic MOSI,
   // Serial data back to the host
   output logic MISO,
   output logic MISO_OE
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [1:0] sck_s_q;
   logic [1:0] cs_s_q;
   logic [1:0] mosi_s_q;
   logic sck_last_q;

   always_ff @(posedge CLK)
   begin
      sck_s_q <= {sck_s_q[0], SCK};
      cs_s_q <= {cs_s_q[0], CS_N};
      mosi_s_q <= {mosi_s_q[0], MOSI};
      sck_last_q <= sck_s_q[1];
   end

   // Edges come from the second stage only, never the first; the
   // stages need no reset since three reset cycles flush them
   wire sck_rise = sck_s_q[1] & ~sck_last_q;
   wire sck_fall = ~sck_s_q[1] & sck_last_q;
   wire selected = ~cs_s_q[1];
   wire mosi_bit = mosi_s_q[1];

   // ****************************************
   // Command sequencer
   // ****************************************
   typedef enum logic [4:0]
   {
      ST_CMD = 5'b00001,
      ST_ADDR = 5'b00010,
      ST_DUMMY = 5'b00100,
      ST_DATA = 5'b01000,
      ST_IGNORE = 5'b10000
   } seq_state_type;

   seq_state_type state_q;
   seq_state_type state_d;
   logic [7:0] shift_q;
   logic [4:0] bit_cnt_q;
   logic [7:0] addr_q;
   logic [7:0] out_q;
   logic miso_q;
   logic miso_oe_q;
   logic [7:0] rom_byte;

   // ****************************************
   // Phase lengths
   // ****************************************
   // Counts are last-bit indices, so a phase ends on its own edge
   localparam logic [4:0] CMD_LAST = 5'(hdr_table_pkg::CMD_BITS - 1);
   localparam logic [4:0] ADDR_LAST =
      5'(hdr_table_pkg::ADDR_BYTES * 8 - 1);
   localparam logic [4:0] DUMMY_LAST = 5'(hdr_table_pkg::DUMMY_BITS - 1);
   localparam logic [4:0] BYTE_LAST = 5'd7;

   // ****************************************
   // Frame phase decode
   // ****************************************
   // A foreign command parks the sequencer until deselect
   wire [7:0] shift_next = {shift_q[6:0], mosi_bit};
   wire cmd_done = (state_q == ST_CMD) && (bit_cnt_q == CMD_LAST);
   wire cmd_ok = shift_next == hdr_table_pkg::CMD_READ_PARAM;
   wire addr_done = (state_q == ST_ADDR) && (bit_cnt_q == ADDR_LAST);
   wire dummy_done = (state_q == ST_DUMMY) && (bit_cnt_q == DUMMY_LAST);
   wire byte_done = (state_q == ST_DATA) && (bit_cnt_q == BYTE_LAST);
   wire phase_end = cmd_done | addr_done | dummy_done | byte_done;

   // ****************************************
   // Table lookup
   // ****************************************
   // Only the low address byte selects within the 256-byte space
   hdr_table_lookup #(
      .MAKER_ID(MAKER_ID)
   ) u_lookup (
      .addr(addr_q),
      .data(rom_byte)
   );

   // ****************************************
   // Next state
   // ****************************************
   // The data phase never ends by count; only deselect leaves it
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_CMD:
            if (cmd_done)
               state_d = cmd_ok ? ST_ADDR : ST_IGNORE;
         ST_ADDR:
            if (addr_done)
               state_d = ST_DUMMY;
         ST_DUMMY:
            if (dummy_done)
               state_d = ST_DATA;
         ST_DATA:
            state_d = ST_DATA;
         ST_IGNORE:
            state_d = ST_IGNORE;
      endcase
   end

   // ****************************************
   // Input side on rising serial edges
   // ****************************************
   // Deselect restarts the sequencer, so a cut frame leaves nothing
   // behind for the next command
   wire seq_clear = RESET || !selected;
   wire [4:0] bit_cnt_next = phase_end ? 5'd0 : bit_cnt_q + 5'd1;

   always_ff @(posedge CLK)
   begin
      if (seq_clear)
      begin
         state_q <= ST_CMD;
         bit_cnt_q <= 5'd0;
         shift_q <= hdr_table_pkg::V_ZERO;
      end
      else if (sck_rise)
      begin
         state_q <= state_d;
         shift_q <= shift_next;
         bit_cnt_q <= bit_cnt_next;
      end
   end

   // ****************************************
   // Address pointer
   // ****************************************
   // Every address bit passes through, so the last byte sent wins;
   // the upper address bytes fall off the 8-bit pointer
   wire addr_take = sck_rise && (state_q == ST_ADDR);
   wire addr_step = sck_rise && byte_done;
   wire [7:0] addr_next = addr_q + 8'h01;

   always_ff @(posedge CLK)
   begin
      if (seq_clear)
         addr_q <= hdr_table_pkg::ADDR_START;
      else if (addr_take)
         addr_q <= shift_next;
      else if (addr_step)
         addr_q <= addr_next;
   end

   // ****************************************
   // Output side on falling serial edges
   // ****************************************
   // Load on the first falling edge of each data byte, so the host
   // samples bit 7 on the next rising edge; wraps past the top.
   wire load_byte = (state_q == ST_DATA) && (bit_cnt_q == 5'd0);
   wire out_step = sck_fall && (state_q == ST_DATA);
   wire [7:0] out_src = load_byte ? rom_byte : out_q;
   wire [7:0] out_next = {out_src[6:0], 1'b0};

   always_ff @(posedge CLK)
   begin
      if (seq_clear)
      begin
         out_q <= hdr_table_pkg::V_ZERO;
         miso_q <= 1'b0;
      end
      else if (out_step)
      begin
         miso_q <= out_src[7];
         out_q <= out_next;
      end
   end

   // ****************************************
   // Pin drive
   // ****************************************
   // The enable follows the first data bit and holds to deselect; the
   // host must keep each serial clock level three system clocks long
   always_ff @(posedge CLK)
   begin
      if (seq_clear)
         miso_oe_q <= 1'b0;
      else if (out_step)
         miso_oe_q <= 1'b1;
   end

   assign MISO = miso_q;
   assign MISO_OE = miso_oe_q;

endmodule : hdr_table_rom

// ### common/hdr_table_pkg.sv
package hdr_table_pkg;

   // ****************************************
   // Command and address space
   // ****************************************
   localparam logic [7:0] CMD_READ_PARAM = 8'h5a;
   localparam logic [7:0] ADDR_START = 8'h00;
   localparam logic [7:0] ADDR_RSV_LO = 8'h20;
   localparam logic [7:0] ADDR_PARAM_DATA = 8'h30;
   localparam int ADDR_BITS = 8;
   localparam int CMD_BITS = 8;
   localparam int ADDR_BYTES = 3;
   localparam int DUMMY_BITS = 8;

   // ****************************************
   // Header byte addresses
   // ****************************************
   localparam logic [7:0] A_SIG0 = 8'h00;
   localparam logic [7:0] A_SIG1 = 8'h01;
   localparam logic [7:0] A_SIG2 = 8'h02;
   localparam logic [7:0] A_SIG3 = 8'h03;
   localparam logic [7:0] A_MINOR = 8'h04;
   localparam logic [7:0] A_MAJOR = 8'h05;
   localparam logic [7:0] A_NHDR = 8'h06;
   localparam logic [7:0] A_PROTO = 8'h07;
   localparam logic [7:0] A_H0_IDL = 8'h08;
   localparam logic [7:0] A_H0_MIN = 8'h09;
   localparam logic [7:0] A_H0_MAJ = 8'h0a;
   localparam logic [7:0] A_H0_LEN = 8'h0b;
   localparam logic [7:0] A_H0_P0 = 8'h0c;
   localparam logic [7:0] A_H0_P1 = 8'h0d;
   localparam logic [7:0] A_H0_P2 = 8'h0e;
   localparam logic [7:0] A_H0_IDH = 8'h0f;
   localparam logic [7:0] A_H1_ID = 8'h10;
   localparam logic [7:0] A_H1_MIN = 8'h11;
   localparam logic [7:0] A_H1_MAJ = 8'h12;
   localparam logic [7:0] A_H1_LEN = 8'h13;
   localparam logic [7:0] A_H1_P0 = 8'h14;
   localparam logic [7:0] A_H1_P1 = 8'h15;
   localparam logic [7:0] A_H1_P2 = 8'h16;
   localparam logic [7:0] A_UNUSED = 8'h17;

   // ****************************************
   // Header byte values
   // ****************************************
   localparam logic [7:0] V_SIG0 = 8'h53;
   localparam logic [7:0] V_SIG1 = 8'h46;
   localparam logic [7:0] V_SIG2 = 8'h44;
   localparam logic [7:0] V_SIG3 = 8'h50;
   localparam logic [7:0] V_MINOR = 8'h08;
   localparam logic [7:0] V_MAJOR = 8'h01;
   localparam logic [7:0] V_NHDR = 8'h01;
   localparam logic [7:0] V_PROTO = 8'hff;
   localparam logic [7:0] V_H0_IDL = 8'h00;
   localparam logic [7:0] V_H0_MIN = 8'h07;
   localparam logic [7:0] V_H0_MAJ = 8'h01;
   localparam logic [7:0] V_H0_LEN = 8'h10;
   localparam logic [7:0] V_H0_P0 = 8'h30;
   localparam logic [7:0] V_H0_IDH = 8'hff;
   localparam logic [7:0] V_H1_MIN = 8'h00;
   localparam logic [7:0] V_H1_MAJ = 8'h01;
   localparam logic [7:0] V_H1_LEN = 8'h03;
   localparam logic [7:0] V_H1_P0 = 8'h70;
   localparam logic [7:0] V_ZERO = 8'h00;
   localparam logic [7:0] V_ONES = 8'hff;
   // Maker code byte; value is arbitrary
   localparam logic [7:0] V_MAKER_DEFAULT = 8'ha5;

endpackage : hdr_table_pkg

// ### rtl/hdr_table_lookup.sv
`timescale 1ns/100ps
module hdr_table_lookup #(
   parameter logic [7:0] MAKER_ID = hdr_table_pkg::V_MAKER_DEFAULT
) (
   // Address in
   input wire logic [7:0] addr,
   // Byte out
   output logic [7:0] data
);

   // ****************************************
   // Fixed table; no write path exists
   // ****************************************
   always_comb
   begin
      unique case (addr)
         hdr_table_pkg::A_SIG0: data = hdr_table_pkg::V_SIG0;
         hdr_table_pkg::A_SIG1: data = hdr_table_pkg::V_SIG1;
         hdr_table_pkg::A_SIG2: data = hdr_table_pkg::V_SIG2;
         hdr_table_pkg::A_SIG3: data = hdr_table_pkg::V_SIG3;
         hdr_table_pkg::A_MINOR: data = hdr_table_pkg::V_MINOR;
         hdr_table_pkg::A_MAJOR: data = hdr_table_pkg::V_MAJOR;
         hdr_table_pkg::A_NHDR: data = hdr_table_pkg::V_NHDR;
         hdr_table_pkg::A_PROTO: data = hdr_table_pkg::V_PROTO;
         hdr_table_pkg::A_H0_IDL: data = hdr_table_pkg::V_H0_IDL;
         hdr_table_pkg::A_H0_MIN: data = hdr_table_pkg::V_H0_MIN;
         hdr_table_pkg::A_H0_MAJ: data = hdr_table_pkg::V_H0_MAJ;
         hdr_table_pkg::A_H0_LEN: data = hdr_table_pkg::V_H0_LEN;
         hdr_table_pkg::A_H0_P0: data = hdr_table_pkg::V_H0_P0;
         hdr_table_pkg::A_H0_P1: data = hdr_table_pkg::V_ZERO;
         hdr_table_pkg::A_H0_P2: data = hdr_table_pkg::V_ZERO;
         hdr_table_pkg::A_H0_IDH: data = hdr_table_pkg::V_H0_IDH;
         hdr_table_pkg::A_H1_ID: data = MAKER_ID;
         hdr_table_pkg::A_H1_MIN: data = hdr_table_pkg::V_H1_MIN;
         hdr_table_pkg::A_H1_MAJ: data = hdr_table_pkg::V_H1_MAJ;
         hdr_table_pkg::A_H1_LEN: data = hdr_table_pkg::V_H1_LEN;
         hdr_table_pkg::A_H1_P0: data = hdr_table_pkg::V_H1_P0;
         hdr_table_pkg::A_H1_P1: data = hdr_table_pkg::V_ZERO;
         hdr_table_pkg::A_H1_P2: data = hdr_table_pkg::V_ZERO;
         hdr_table_pkg::A_UNUSED: data = hdr_table_pkg::V_ONES;
         // Reserved header space and everything past it reads as ones
         default: data = hdr_table_pkg::V_ONES;
      endcase
   end

endmodule : hdr_table_lookup

// ### verif/hdr_table_rom_checker.sv
`timescale 1ns/100ps
// ****
// Serial answer checks
// ****
module hdr_table_rom_checker (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // Serial pins
   input wire logic SCK,
   input wire logic CS_N,
   input wire logic MOSI,
   input wire logic MISO,
   input wire logic MISO_OE
);
   logic sck_q;
   logic [7:0] rises_q;
   logic [7:0] cmd_q;
   logic [7:0] adr_q;
   wire logic rise = SCK & ~sck_q;
   wire logic in_cmd = rise && rises_q < 8'h08;
   wire logic in_adr = rise && rises_q >= 8'h18 && rises_q < 8'h20;
   always_ff @(posedge CLK)
   begin
      sck_q <= SCK;
      rises_q <= (RESET || CS_N) ? 8'h00 : rises_q + {7'h00, rise};
      cmd_q <= in_cmd ? {cmd_q[6:0], MOSI} : cmd_q;
      adr_q <= in_adr ? {adr_q[6:0], MOSI} : adr_q;
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   property p_reset; $fell(RESET) |-> !MISO_OE && !MISO; endproperty
   property p_oe_40; $rose(MISO_OE) |-> rises_q == 8'h28; endproperty
   property p_oe_cmd; $rose(MISO_OE) |-> cmd_q == 8'h5a; endproperty
   property p_desel; CS_N [*6] |-> !MISO_OE; endproperty
   property p_oe_hold; MISO_OE && !CS_N |=> MISO_OE; endproperty
   property p_edge; MISO_OE && $changed(MISO) |-> !SCK; endproperty
   property p_stable; $rose(SCK) && MISO_OE |=> $stable(MISO) [*3];
   endproperty
   property p_ones; $rose(MISO_OE) && adr_q >= 8'h17 |-> MISO; endproperty
   a_reset: assert property (p_reset)
      else $error("serial output active after reset");
   a_oe_40: assert property (p_oe_40)
      else $error("data began at the wrong bit count");
   a_oe_cmd: assert property (p_oe_cmd)
      else $error("data driven for a foreign command");
   a_desel: assert property (p_desel)
      else $error("output still enabled when deselected");
   a_oe_hold: assert property (p_oe_hold)
      else $error("output enable dropped while selected");
   a_edge: assert property (p_edge)
      else $error("data changed while serial clock high");
   a_stable: assert property (p_stable)
      else $error("data moved after a serial clock rise");
   a_ones: assert property (p_ones)
      else $error("unused byte did not start with a one");
   c_read: cover property ($rose(MISO_OE));
   c_wrap: cover property ($rose(MISO_OE) && adr_q == 8'hff);
   c_long: cover property (MISO_OE && rises_q == 8'h38);
   c_refused: cover property ($rose(CS_N) && rises_q > 8'h28 && !cmd_q[6]);
endmodule : hdr_table_rom_checker

bind hdr_table_rom hdr_table_rom_checker chk (.CLK(CLK), .RESET(RESET),
   .SCK(SCK), .CS_N(CS_N), .MOSI(MOSI), .MISO(MISO), .MISO_OE(MISO_OE));

// ### verif/spi_host.sv
`timescale 1ns/100ps
module spi_host (
   // Clock
   input wire logic clk,
   // Device answer
   input wire logic miso,
   input wire logic miso_oe,
   // Serial pins
   output logic sck,
   output logic cs_n,
   output logic mosi
);
   logic [7:0] rx [0:31];
   logic oe_seen;
   // Set when a data bit is taken while the device is not driving
   logic oe_gap;
   initial
   begin
      sck = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // Levels of 6 CLK leave room for the device's synchroniser
   task automatic frame(input logic [7:0] cmd, input logic [7:0] adr,
      input int n);
      logic [39:0] hdr;
      hdr = {cmd, 16'h0000, adr, 8'h00};
      oe_seen = 1'b0;
      oe_gap = 1'b0;
      cs_n = 1'b0;
      for (int i = 0; i < 40 + 8 * n; i++)
      begin
         mosi = (i < 40) ? hdr[39 - i] : ~mosi;
         repeat (6) @(negedge clk);
         if (i >= 40)
         begin
            rx[(i - 40) / 8][7 - i % 8] = miso;
            oe_gap |= ~miso_oe;
         end
         oe_seen |= miso_oe;
         sck = 1'b1;
         repeat (6) @(negedge clk);
         sck = 1'b0;
      end
      repeat (2) @(negedge clk);
      cs_n = 1'b1;
      // Toggle so an unselected device never sees a stale level
      mosi = ~mosi;
      repeat (8) @(negedge clk);
   endtask : frame
endmodule : spi_host

// ### verif/tb_hdr_table_rom.sv
`timescale 1ns/100ps
module tb_hdr_table_rom;
   localparam logic [7:0] MAKER = 8'h3c; // Arbitrary maker code
   logic CLK = 1'b0;
   logic RESET = 1'b1;
   logic SCK, CS_N, MOSI, MISO, MISO_OE;
   int num_errors = 0;
   int comparisons = 0;
   logic [7:0] hdr [0:23] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h08, 8'h01,
      8'h01, 8'hff, 8'h00, 8'h07, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00,
      8'hff, MAKER, 8'h00, 8'h01, 8'h03, 8'h70, 8'h00, 8'h00, 8'hff};
   always #20 CLK = ~CLK;
   hdr_table_rom #(.MAKER_ID(MAKER)) dut (.CLK(CLK), .RESET(RESET),
      .SCK(SCK), .CS_N(CS_N), .MOSI(MOSI), .MISO(MISO),
      .MISO_OE(MISO_OE));
   spi_host host (.clk(CLK), .miso(MISO), .miso_oe(MISO_OE), .sck(SCK),
      .cs_n(CS_N), .mosi(MOSI));
   task automatic print_verdict;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   task automatic check_flag(input logic got, input logic exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check_flag
   // Beyond the header the parameter tables are not modelled: all ones
   function automatic logic [7:0] exp_byte(input logic [7:0] a);
      return (a < 8'h18) ? hdr[a] : 8'hff;
   endfunction : exp_byte
   task automatic cmp_rx(input logic [7:0] start, input int lo, input int n);
      for (int i = lo; i < lo + n; i++)
         check(host.rx[i], exp_byte(start + 8'(i)));
   endtask : cmp_rx
   task automatic t_header;
      host.frame(8'h5a, 8'h00, 24);
      cmp_rx(8'h00, 0, 8);
      cmp_rx(8'h00, 8, 8);
      cmp_rx(8'h00, 16, 8);
      check_flag(host.oe_gap, 1'b0);
   endtask : t_header
   task automatic t_span;
      host.frame(8'h5a, 8'h15, 4);
      cmp_rx(8'h15, 0, 4);
      host.frame(8'h5a, 8'h1e, 4);
      cmp_rx(8'h1e, 0, 4);
      host.frame(8'h5a, 8'h2e, 3);
      cmp_rx(8'h2e, 0, 3);
   endtask : t_span
   task automatic t_wrap;
      host.frame(8'h5a, 8'hff, 2);
      check_flag(host.oe_seen, 1'b1);
      cmp_rx(8'hff, 0, 2);
   endtask : t_wrap
   task automatic t_refuse;
      host.frame(8'h02, 8'h00, 2);
      check_flag(host.oe_seen, 1'b0);
      host.frame(8'h20, 8'h00, 2);
      check_flag(host.oe_seen, 1'b0);
      host.frame(8'h5a, 8'h00, 4);
      cmp_rx(8'h00, 0, 4);
   endtask : t_refuse
   initial
   begin
      repeat (3) @(negedge CLK);
      RESET = 1'b0;
      repeat (4) @(negedge CLK);
      t_header();
      t_span();
      t_wrap();
      t_refuse();
      print_verdict();
   end
   // Whole run needs about 8250 cycles
   initial
   begin
      repeat (20000) @(posedge CLK);
      num_errors++;
      print_verdict();
   end
endmodule : tb_hdr_table_rom
